// [inc/fan_pkg.sv]
package fan_pkg;
   // Clock and PWM timing
   localparam int unsigned CLK_HZ         = 250_000_000;
   localparam int unsigned PWM_FREQ_HZ    = 25_000;
   localparam int unsigned PWM_STEPS      = 100;
   localparam int unsigned PWM_PRE_CYCLES = CLK_HZ / (PWM_FREQ_HZ * PWM_STEPS);

   localparam logic [7:0] DUTY_MAX = 8'h64;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_RAMP     = 8'h04;
   localparam logic [7:0] OFS_AIRV_LUT = 8'h08;
   localparam logic [7:0] OFS_AIRV_RNG = 8'h0C;
   localparam logic [7:0] OFS_PERF_MIN = 8'h10;
   localparam logic [7:0] OFS_LEG_DIE  = 8'h14;
   localparam logic [7:0] OFS_DOM_CFG  = 8'h20;
   localparam logic [7:0] OFS_DOM_STAT = 8'h30;
   localparam logic [7:0] OFS_CTL_CFG  = 8'h40;
   localparam logic [7:0] OFS_DIMM_OFS = 8'h80;
   localparam logic [7:0] OFS_DIMM_EST = 8'hA0;

   // CTRL fields
   localparam int unsigned CTRL_PERF_BIT   = 0;
   localparam int unsigned CTRL_STATIC_BIT = 1;

   // Entry type encoding
   localparam logic ENTRY_STEPWISE = 1'b0;
   localparam logic ENTRY_CLAMP    = 1'b1;

   // Reset values
   localparam logic [31:0] RST_CTRL     = 32'h0000_0000;
   localparam logic [31:0] RST_RAMP     = 32'h0000_0001;
   localparam logic [31:0] RST_AIRV_LUT = 32'h4030_2010;
   localparam logic [31:0] RST_AIRV_RNG = 32'h0000_3820;
   localparam logic [31:0] RST_PERF_MIN = 32'h0000_0032;
   localparam logic [31:0] RST_DOM_CFG  = 32'h0064_3201;
   localparam logic [31:0] RST_CTL_CFG  = 32'h0000_0000;
   localparam logic [31:0] RST_DIMM_OFS = 32'h0000_0000;
endpackage

// [design/pwm_gen.sv]
`timescale 1ns/1ps
module pwm_gen #(
   parameter int unsigned N_OUT = 2,
   parameter int unsigned STEPS = fan_pkg::PWM_STEPS,
   parameter int unsigned PRE   = fan_pkg::PWM_PRE_CYCLES
) (
   input  wire logic               clk,
   input  wire logic               srst,
   input  wire logic [N_OUT*8-1:0] duty,
   output logic      [N_OUT-1:0]   pwm,
   output logic                    period_tick
);
   logic [15:0] pre_r;
   logic [15:0] pre_nxt;
   logic [7:0]  step_r;
   logic [7:0]  step_nxt;
   logic [N_OUT-1:0] pwm_r;
   logic [N_OUT-1:0] pwm_nxt;
   logic             tick_r;
   logic             tick_nxt;

   // One shared period counter serves every output
   always_comb begin
      pre_nxt  = pre_r + 16'h0001;
      step_nxt = step_r;
      tick_nxt = 1'b0;
      // Tick two cycles early so a ramped duty is in place when the period starts; needs PRE of 3 or more
      if (step_r == 8'(STEPS - 1) && pre_r == 16'(PRE - 3)) begin
         tick_nxt = 1'b1;
      end
      if (pre_r == 16'(PRE - 1)) begin
         pre_nxt  = 16'h0000;
         step_nxt = step_r + 8'h01;
         if (step_r == 8'(STEPS - 1)) begin
            step_nxt = 8'h00;
         end
      end
      for (int i = 0; i < N_OUT; i++) begin
         pwm_nxt[i] = step_nxt < duty[i*8 +: 8];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pre_r  <= 16'h0000;
         step_r <= 8'h00;
         pwm_r  <= '0;
         tick_r <= 1'b0;
      end else begin
         pre_r  <= pre_nxt;
         step_r <= step_nxt;
         pwm_r  <= pwm_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign pwm         = pwm_r;
   assign period_tick = tick_r;
endmodule

// [design/fan_domain_pwm_control.sv]
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module fan_domain_pwm_control #(
   parameter int unsigned N_DOM  = 2,
   parameter int unsigned N_CTL  = 4,
   parameter int unsigned N_DIMM = 2
) (
   input  wire logic                CLK,
   input  wire logic                SRST,
   input  wire logic [7:0]          AVS_ADDRESS,
   input  wire logic                AVS_READ,
   input  wire logic                AVS_WRITE,
   input  wire logic [31:0]         AVS_WRITEDATA,
   input  wire logic [3:0]          AVS_BYTEENABLE,
   output logic      [31:0]         AVS_READDATA,
   output logic                     AVS_WAITREQUEST,
   input  wire logic [7:0]          CPU_MARGIN,
   input  wire logic [7:0]          DIMM_MARGIN,
   input  wire logic [15:0]         BOARD_TEMP,
   input  wire logic [7:0]          DIE_THERMAL_READING,
   input  wire logic [N_DIMM*8-1:0] DIMM_SENSOR_READING,
   input  wire logic [N_DOM-1:0]    BOOST,
   output logic      [N_DOM-1:0]    PWM_OUT,
   output logic      [N_DIMM-1:0]   MC_OFS_WE,
   output logic      [N_DIMM*8-1:0] MC_OFS_DATA
);
   // Bus and configuration state
   logic        ack_r;
   logic        ack_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [31:0] ctrl_r;
   logic [31:0] ctrl_nxt;
   logic [31:0] ramp_r;
   logic [31:0] ramp_nxt;
   logic [31:0] lut_r;
   logic [31:0] lut_nxt;
   logic [31:0] rng_r;
   logic [31:0] rng_nxt;
   logic [31:0] pmin_r;
   logic [31:0] pmin_nxt;
   logic [31:0] dcfg_r [N_DOM];
   logic [31:0] dcfg_nxt [N_DOM];
   logic [31:0] ccfg_r [N_CTL*2];
   logic [31:0] ccfg_nxt [N_CTL*2];
   logic [31:0] mofs_r [N_DIMM];
   logic [31:0] mofs_nxt [N_DIMM];

   // Engine state
   logic [7:0]  teff_r [N_CTL];
   logic [7:0]  teff_nxt [N_CTL];
   logic [7:0]  cur_r [N_DOM];
   logic [7:0]  cur_nxt [N_DOM];
   logic [15:0] rcnt_r [N_DOM];
   logic [15:0] rcnt_nxt [N_DOM];
   logic [7:0]  aofs_r [N_DIMM];
   logic [7:0]  aofs_nxt [N_DIMM];
   logic [N_DIMM-1:0] we_r;
   logic [N_DIMM-1:0] we_nxt;

   // Combinational results
   logic [7:0]  contrib [N_CTL];
   logic [7:0]  target [N_DOM];
   logic [7:0]  airv [N_DOM];
   logic [1:0]  vrange [N_DOM];
   logic [7:0]  est [N_DIMM];
   logic [N_DOM*8-1:0] duty_flat;
   logic        tick;
   logic        req;
   logic        wr_go;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [7:0] sat(input logic [15:0] v);
      return (v > 16'(fan_pkg::DUTY_MAX)) ? fan_pkg::DUTY_MAX : v[7:0];
   endfunction

   // Source 0 is the processor margin, 1 the DIMM aggregate margin; legacy die reading is never a source
   function automatic logic [7:0] src_sel(input logic [1:0] s, input logic [7:0] cpu,
                                          input logic [7:0] dimm, input logic [15:0] brd);
      case (s)
         2'b00:   return cpu;
         2'b01:   return dimm;
         2'b10:   return brd[7:0];
         default: return brd[15:8];
      endcase
   endfunction

   assign req             = AVS_READ | AVS_WRITE;
   // One wait cycle per access; the access completes when ack_r is high
   assign AVS_WAITREQUEST = req & ~ack_r;
   assign wr_go           = AVS_WRITE & ack_r;
   assign AVS_READDATA    = rdata_r;
   assign MC_OFS_WE       = we_r;

   // Per-entry contribution
   generate
      for (genvar c = 0; c < N_CTL; c++) begin : g_ctl
         logic [31:0] c0;
         logic [31:0] c1;
         logic [7:0]  t;
         logic [7:0]  diff;
         assign c0 = ccfg_r[2*c];
         assign c1 = ccfg_r[2*c+1];
         assign t  = teff_r[c];
         // Stepwise rises with temperature above the knee; clamp rises as margin falls below it
         always_comb begin
            diff = 8'h00;
            if (c0[1] == fan_pkg::ENTRY_STEPWISE && t > c1[7:0]) begin
               diff = t - c1[7:0];
            end else if (c0[1] == fan_pkg::ENTRY_CLAMP && t < c1[7:0]) begin
               diff = c1[7:0] - t;
            end
            contrib[c] = sat(16'(c1[15:8]) + 16'(c1[23:16]) * 16'(diff));
         end
      end
   endgenerate

   // Domain combination, air velocity and range
   always_comb begin
      logic [7:0]  smax;
      logic [15:0] csum;
      logic [7:0]  cap;
      logic [7:0]  nom;
      smax = 8'h00;
      csum = 16'h0000;
      cap  = fan_pkg::DUTY_MAX;
      nom  = 8'h00;
      for (int d = 0; d < N_DOM; d++) begin
         smax = 8'h00;
         csum = 16'h0000;
         cap  = fan_pkg::DUTY_MAX;
         for (int c = 0; c < N_CTL; c++) begin
            // ccfg0: [0] en, [1] type, [2] max entry, [5:4] domain, [9:8] source, [23:16] hyst
            if (ccfg_r[2*c][0] && ccfg_r[2*c][5:4] == 2'(d)) begin
               if (ccfg_r[2*c][1] == fan_pkg::ENTRY_CLAMP) begin
                  csum = csum + 16'(contrib[c]);
               end else if (ccfg_r[2*c][2]) begin
                  cap = (contrib[c] < cap) ? contrib[c] : cap;
               end else if (contrib[c] > smax) begin
                  smax = contrib[c];
               end
            end
         end
         nom = (16'(smax) > csum) ? smax : sat(csum);
         nom = (nom > cap) ? cap : nom;
         if (dcfg_r[d][0]) begin
            nom = sat(16'(dcfg_r[d][15:8]));
         end
         if (ctrl_r[fan_pkg::CTRL_PERF_BIT] && nom < pmin_r[7:0]) begin
            nom = sat(16'(pmin_r[7:0]));
         end
         target[d] = nom;
         airv[d]   = lut_r[cur_r[d][7:5]*8 +: 8] ;
         if (airv[d] >= rng_r[15:8]) begin
            vrange[d] = 2'd2;
         end else if (airv[d] >= rng_r[7:0]) begin
            vrange[d] = 2'd1;
         end else begin
            vrange[d] = 2'd0;
         end
      end
   end

   // Bus access and configuration registers
   always_comb begin
      ack_nxt   = req & ~ack_r;
      rdata_nxt = rdata_r;
      ctrl_nxt  = ctrl_r;
      ramp_nxt  = ramp_r;
      lut_nxt   = lut_r;
      rng_nxt   = rng_r;
      pmin_nxt  = pmin_r;
      dcfg_nxt  = dcfg_r;
      ccfg_nxt  = ccfg_r;
      mofs_nxt  = mofs_r;
      if (wr_go) begin
         case (AVS_ADDRESS)
            fan_pkg::OFS_CTRL:     ctrl_nxt = merge(ctrl_r, AVS_WRITEDATA, AVS_BYTEENABLE);
            fan_pkg::OFS_RAMP:     ramp_nxt = merge(ramp_r, AVS_WRITEDATA, AVS_BYTEENABLE);
            fan_pkg::OFS_AIRV_LUT: lut_nxt  = merge(lut_r, AVS_WRITEDATA, AVS_BYTEENABLE);
            fan_pkg::OFS_AIRV_RNG: rng_nxt  = merge(rng_r, AVS_WRITEDATA, AVS_BYTEENABLE);
            fan_pkg::OFS_PERF_MIN: pmin_nxt = merge(pmin_r, AVS_WRITEDATA, AVS_BYTEENABLE);
            default: begin
            end
         endcase
         for (int d = 0; d < N_DOM; d++) begin
            if (AVS_ADDRESS == fan_pkg::OFS_DOM_CFG + 8'(4*d)) begin
               dcfg_nxt[d] = merge(dcfg_r[d], AVS_WRITEDATA, AVS_BYTEENABLE);
            end
         end
         for (int c = 0; c < N_CTL*2; c++) begin
            if (AVS_ADDRESS == fan_pkg::OFS_CTL_CFG + 8'(4*c)) begin
               ccfg_nxt[c] = merge(ccfg_r[c], AVS_WRITEDATA, AVS_BYTEENABLE);
            end
         end
         for (int k = 0; k < N_DIMM; k++) begin
            if (AVS_ADDRESS == fan_pkg::OFS_DIMM_OFS + 8'(4*k)) begin
               mofs_nxt[k] = merge(mofs_r[k], AVS_WRITEDATA, AVS_BYTEENABLE);
            end
         end
      end
      // Read data latched in the wait cycle, so it stands when waitrequest drops
      if (AVS_READ & ~ack_r) begin
         rdata_nxt = 32'h0000_0000;
         case (AVS_ADDRESS)
            fan_pkg::OFS_CTRL:     rdata_nxt = {30'h0000_0000, ctrl_r[1:0]};
            fan_pkg::OFS_RAMP:     rdata_nxt = {16'h0000, ramp_r[15:0]};
            fan_pkg::OFS_AIRV_LUT: rdata_nxt = lut_r;
            fan_pkg::OFS_AIRV_RNG: rdata_nxt = {16'h0000, rng_r[15:0]};
            fan_pkg::OFS_PERF_MIN: rdata_nxt = {24'h00_0000, pmin_r[7:0]};
            fan_pkg::OFS_LEG_DIE:  rdata_nxt = {24'h00_0000, DIE_THERMAL_READING};
            default: begin
            end
         endcase
         for (int d = 0; d < N_DOM; d++) begin
            if (AVS_ADDRESS == fan_pkg::OFS_DOM_CFG + 8'(4*d)) begin
               rdata_nxt = {8'h00, dcfg_r[d][23:8], 7'h00, dcfg_r[d][0]};
            end
            if (AVS_ADDRESS == fan_pkg::OFS_DOM_STAT + 8'(4*d)) begin
               rdata_nxt = {BOOST[d], 5'h00, vrange[d], airv[d], target[d], cur_r[d]};
            end
         end
         for (int c = 0; c < N_CTL*2; c++) begin
            if (AVS_ADDRESS == fan_pkg::OFS_CTL_CFG + 8'(4*c)) begin
               rdata_nxt = ccfg_r[c];
            end
         end
         for (int k = 0; k < N_DIMM; k++) begin
            if (AVS_ADDRESS == fan_pkg::OFS_DIMM_OFS + 8'(4*k)) begin
               rdata_nxt = mofs_r[k];
            end
            if (AVS_ADDRESS == fan_pkg::OFS_DIMM_EST + 8'(4*k)) begin
               rdata_nxt = {16'h0000, aofs_r[k], est[k]};
            end
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         ack_r   <= 1'b0;
         rdata_r <= 32'h0000_0000;
         ctrl_r  <= fan_pkg::RST_CTRL;
         ramp_r  <= fan_pkg::RST_RAMP;
         lut_r   <= fan_pkg::RST_AIRV_LUT;
         rng_r   <= fan_pkg::RST_AIRV_RNG;
         pmin_r  <= fan_pkg::RST_PERF_MIN;
         for (int d = 0; d < N_DOM; d++) begin
            dcfg_r[d] <= fan_pkg::RST_DOM_CFG;
         end
         for (int c = 0; c < N_CTL*2; c++) begin
            ccfg_r[c] <= fan_pkg::RST_CTL_CFG;
         end
         for (int k = 0; k < N_DIMM; k++) begin
            mofs_r[k] <= fan_pkg::RST_DIMM_OFS;
         end
      end else begin
         ack_r   <= ack_nxt;
         rdata_r <= rdata_nxt;
         ctrl_r  <= ctrl_nxt;
         ramp_r  <= ramp_nxt;
         lut_r   <= lut_nxt;
         rng_r   <= rng_nxt;
         pmin_r  <= pmin_nxt;
         dcfg_r  <= dcfg_nxt;
         ccfg_r  <= ccfg_nxt;
         mofs_r  <= mofs_nxt;
      end
   end

   // Hysteresis, ramp and memory offset engine
   always_comb begin
      logic [7:0] t;
      logic [7:0] sel;
      logic [7:0] want;
      teff_nxt = teff_r;
      cur_nxt  = cur_r;
      rcnt_nxt = rcnt_r;
      aofs_nxt = aofs_r;
      we_nxt   = '0;
      t        = 8'h00;
      sel      = 8'h00;
      want     = 8'h00;
      for (int c = 0; c < N_CTL; c++) begin
         t = src_sel(ccfg_r[2*c][9:8], CPU_MARGIN, DIMM_MARGIN, BOARD_TEMP);
         // Reset leaves the hysteresis field zero, so the entry tracks every change
         if ((t > teff_r[c] && t - teff_r[c] > ccfg_r[2*c][23:16]) ||
             (t < teff_r[c] && teff_r[c] - t > ccfg_r[2*c][23:16])) begin
            teff_nxt[c] = t;
         end
      end
      for (int d = 0; d < N_DOM; d++) begin
         want = BOOST[d] ? sat(16'(dcfg_r[d][23:16])) : target[d];
         if (BOOST[d]) begin
            // Boost steps at once: cooling loss must not wait for the ramp
            cur_nxt[d]  = want;
            rcnt_nxt[d] = 16'h0000;
         end else if (tick && cur_r[d] != want) begin
            if (rcnt_r[d] + 16'h0001 >= ramp_r[15:0]) begin
               rcnt_nxt[d] = 16'h0000;
               cur_nxt[d]  = (cur_r[d] < want) ? cur_r[d] + 8'h01 : cur_r[d] - 8'h01;
            end else begin
               rcnt_nxt[d] = rcnt_r[d] + 16'h0001;
            end
         end
      end
      for (int k = 0; k < N_DIMM; k++) begin
         // DIMM k follows domain k mod N_DOM for its airflow
         case (vrange[k % N_DOM])
            2'd0:    sel = mofs_r[k][7:0];
            2'd1:    sel = mofs_r[k][15:8];
            default: sel = mofs_r[k][23:16];
         endcase
         if (ctrl_r[fan_pkg::CTRL_STATIC_BIT]) begin
            sel = mofs_r[k][31:24];
         end
         if (tick) begin
            // Running average smooths jumps at velocity range edges
            aofs_nxt[k] = 8'((9'(aofs_r[k]) + 9'(sel) + 9'd1) >> 1);
            we_nxt[k]   = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         we_r <= '0;
         for (int c = 0; c < N_CTL; c++) begin
            teff_r[c] <= 8'h00;
         end
         for (int d = 0; d < N_DOM; d++) begin
            cur_r[d]  <= 8'h00;
            rcnt_r[d] <= 16'h0000;
         end
         for (int k = 0; k < N_DIMM; k++) begin
            aofs_r[k] <= 8'h00;
         end
      end else begin
         we_r   <= we_nxt;
         teff_r <= teff_nxt;
         cur_r  <= cur_nxt;
         rcnt_r <= rcnt_nxt;
         aofs_r <= aofs_nxt;
      end
   end

   always_comb begin
      for (int k = 0; k < N_DIMM; k++) begin
         est[k]            = DIMM_SENSOR_READING[k*8 +: 8] + aofs_r[k];
         MC_OFS_DATA[k*8 +: 8] = aofs_r[k];
      end
      for (int d = 0; d < N_DOM; d++) begin
         duty_flat[d*8 +: 8] = cur_r[d];
      end
   end

   pwm_gen #(
      .N_OUT (N_DOM)
   ) u_pwm (
      .clk         (CLK),
      .srst        (SRST),
      .duty        (duty_flat),
      .pwm         (PWM_OUT),
      .period_tick (tick)
   );
endmodule

// [test/fan_domain_pwm_control_chk.sv]
`timescale 1ns/1ps
module fan_domain_pwm_control_chk #(
   parameter int unsigned N_DOM  = 2,
   parameter int unsigned N_CTL  = 4,
   parameter int unsigned N_DIMM = 2
) (
   input wire logic                CLK,
   input wire logic                SRST,
   input wire logic [7:0]          AVS_ADDRESS,
   input wire logic                AVS_READ,
   input wire logic                AVS_WRITE,
   input wire logic [31:0]         AVS_READDATA,
   input wire logic                AVS_WAITREQUEST,
   input wire logic [N_DOM-1:0]    BOOST,
   input wire logic [N_DOM-1:0]    PWM_OUT,
   input wire logic [N_DIMM-1:0]   MC_OFS_WE,
   input wire logic [N_DIMM*8-1:0] MC_OFS_DATA
);
   localparam int PERIOD = fan_pkg::PWM_STEPS * fan_pkg::PWM_PRE_CYCLES;
   logic [15:0] since_r;
   logic [15:0] since_nxt;
   logic        prev_r;
   logic        seen_r;
   logic        seen_nxt;
   logic        rise;
   // Rises of the output must stay on the period grid
   always_comb begin
      rise      = PWM_OUT[0] & ~prev_r;
      since_nxt = rise ? 16'h0001 : ((since_r == 16'hFFFF) ? since_r : since_r + 16'h0001);
      seen_nxt  = seen_r | rise;
   end
   always_ff @(posedge CLK) begin
      if (SRST) begin
         since_r <= 16'h0000;
         prev_r  <= 1'b0;
         seen_r  <= 1'b0;
      end else begin
         since_r <= since_nxt;
         prev_r  <= PWM_OUT[0];
         seen_r  <= seen_nxt;
      end
   end
   a_wait_new: assert property (@(posedge CLK) disable iff (SRST)
      ($rose(AVS_READ) || $rose(AVS_WRITE)) |-> AVS_WAITREQUEST) else $error("waitrequest low on new access");
   a_wait_one: assert property (@(posedge CLK) disable iff (SRST)
      ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST) else $error("waitrequest too long");
   a_wait_idle: assert property (@(posedge CLK) disable iff (SRST)
      !(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST) else $error("waitrequest while idle");
   a_rdata_hold: assert property (@(posedge CLK) disable iff (SRST)
      (!AVS_READ && !$past(AVS_READ)) |-> $stable(AVS_READDATA)) else $error("read data moved without read");
   // Checks the reset itself, so it cannot be disabled by it
   a_reset_quiet: assert property (@(posedge CLK)
      SRST |=> (PWM_OUT == '0 && MC_OFS_WE == '0 && MC_OFS_DATA == '0)) else $error("outputs not cleared");
   a_pwm_grid: assert property (@(posedge CLK) disable iff (SRST)
      (rise && seen_r && since_r != 16'hFFFF) |-> (since_r % PERIOD == 0)) else $error("pwm rise off period");
   a_boost_full: assert property (@(posedge CLK) disable iff (SRST)
      BOOST[1] [*4] |-> PWM_OUT[1]) else $error("boosted domain not full on");
   a_ofs_once: assert property (@(posedge CLK) disable iff (SRST)
      MC_OFS_WE[0] |=> (!MC_OFS_WE[0]) [*8]) else $error("offset strobe too wide");
   a_ofs_with_we: assert property (@(posedge CLK) disable iff (SRST)
      $changed(MC_OFS_DATA[7:0]) |-> MC_OFS_WE[0]) else $error("offset changed silently");
endmodule

bind fan_domain_pwm_control fan_domain_pwm_control_chk #(.N_DOM(N_DOM), .N_CTL(N_CTL), .N_DIMM(N_DIMM)) chk_i (
   .CLK(CLK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .BOOST(BOOST), .PWM_OUT(PWM_OUT),
   .MC_OFS_WE(MC_OFS_WE), .MC_OFS_DATA(MC_OFS_DATA));

// [test/fan_side_model.sv]
`timescale 1ns/1ps
module fan_side_model #(
   parameter int unsigned N_DOM  = 2,
   parameter int unsigned N_DIMM = 2
) (
   input  wire logic                clk,
   input  wire logic [N_DOM-1:0]    pwm,
   input  wire logic [N_DIMM-1:0]   ofs_we,
   input  wire logic [N_DIMM*8-1:0] ofs_data,
   output logic      [N_DIMM*8-1:0] sensor
);
   int         run[N_DOM];
   int         hi_len[N_DOM];
   logic [7:0] ofs[N_DIMM];
   // Fans: width of the last full high pulse per domain
   always @(posedge clk) begin
      for (int d = 0; d < N_DOM; d++) begin
         if (pwm[d]) begin
            run[d] <= run[d] + 1;
         end else begin
            if (run[d] != 0) hi_len[d] <= run[d];
            run[d] <= 0;
         end
      end
      for (int k = 0; k < N_DIMM; k++) begin
         if (ofs_we[k]) ofs[k] <= ofs_data[k*8 +: 8];
      end
   end
   // Fixed readings stand for the controller's estimate too, as polling may pause
   always_comb begin
      for (int k = 0; k < N_DIMM; k++) sensor[k*8 +: 8] = 8'h28 + 8'(k);
   end
endmodule

// [test/test_fan_domain_pwm_control.sv]
`timescale 1ns/1ps
module test_fan_domain_pwm_control;
   localparam int PER   = fan_pkg::PWM_STEPS * fan_pkg::PWM_PRE_CYCLES;
   localparam int LIMIT = 95000;
   logic        CLK, SRST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
   logic [7:0]  AVS_ADDRESS, CPU_MARGIN, DIMM_MARGIN, DIE_THERMAL_READING;
   logic [31:0] AVS_WRITEDATA, AVS_READDATA, v;
   logic [15:0] BOARD_TEMP, DIMM_SENSOR_READING, MC_OFS_DATA;
   logic [1:0]  BOOST, PWM_OUT, MC_OFS_WE;
   logic [3:0]  AVS_BYTEENABLE;
   int          miscompares, compares, cyc;

   fan_domain_pwm_control uut (.CLK(CLK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
      .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .CPU_MARGIN(CPU_MARGIN),
      .DIMM_MARGIN(DIMM_MARGIN), .BOARD_TEMP(BOARD_TEMP), .DIE_THERMAL_READING(DIE_THERMAL_READING),
      .DIMM_SENSOR_READING(DIMM_SENSOR_READING), .BOOST(BOOST), .PWM_OUT(PWM_OUT),
      .MC_OFS_WE(MC_OFS_WE), .MC_OFS_DATA(MC_OFS_DATA));
   fan_side_model mdl (.clk(CLK), .pwm(PWM_OUT), .ofs_we(MC_OFS_WE), .ofs_data(MC_OFS_DATA),
      .sensor(DIMM_SENSOR_READING));

   task automatic summarize();
      if (miscompares == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   // One access; held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge CLK);
      AVS_ADDRESS   <= a;
      AVS_WRITEDATA <= wd;
      AVS_WRITE     <= wr;
      AVS_READ      <= !wr;
      do begin
         @(posedge CLK);
         n++;
      end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
      if (n >= 50) chk("waitrequest", 32'h0000_0001, 32'h0000_0000);
      rd = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ  <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, a, 32'h0000_0000, x);
      chk(name, x, exp);
   endtask
   // Target field of domain 0 after inputs settle
   task automatic tgt(input logic [7:0] exp);
      logic [31:0] x;
      repeat (6) @(posedge CLK);
      bus(1'b0, fan_pkg::OFS_DOM_STAT, 32'h0000_0000, x);
      chk("target", {24'h00_0000, x[15:8]}, {24'h00_0000, exp});
   endtask

   initial begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         miscompares++;
         summarize();
      end
   end

   initial begin
      {SRST, AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA, BOOST, cyc} = '0;
      SRST = 1'b1;
      AVS_BYTEENABLE = 4'hF;
      CPU_MARGIN = 8'h1E;
      DIMM_MARGIN = 8'h40;
      BOARD_TEMP = 16'h0034;
      DIE_THERMAL_READING = 8'hA5;
      repeat (10) @(posedge CLK);
      SRST <= 1'b0;
      chk("pwm_reset", {30'h0, PWM_OUT}, 32'h0000_0000);
      rdchk("ctrl", fan_pkg::OFS_CTRL, fan_pkg::RST_CTRL);
      rdchk("ramp", fan_pkg::OFS_RAMP, fan_pkg::RST_RAMP);
      rdchk("lut", fan_pkg::OFS_AIRV_LUT, fan_pkg::RST_AIRV_LUT);
      rdchk("rng", fan_pkg::OFS_AIRV_RNG, fan_pkg::RST_AIRV_RNG);
      rdchk("pmin", fan_pkg::OFS_PERF_MIN, fan_pkg::RST_PERF_MIN);
      rdchk("domcfg", fan_pkg::OFS_DOM_CFG, fan_pkg::RST_DOM_CFG);
      rdchk("ctlcfg", fan_pkg::OFS_CTL_CFG, fan_pkg::RST_CTL_CFG);
      rdchk("dimmofs", fan_pkg::OFS_DIMM_OFS, fan_pkg::RST_DIMM_OFS);
      rdchk("legdie", fan_pkg::OFS_LEG_DIE, 32'h0000_00A5);
      wr(8'h18, 32'hFFFF_FFFF);
      rdchk("unmapped", 8'h18, 32'h0000_0000);
      rdchk("ramp_start", fan_pkg::OFS_DOM_STAT, 32'h0010_3200);
      wr(fan_pkg::OFS_DIMM_OFS, 32'h0530_2010);
      wr(fan_pkg::OFS_DIMM_OFS + 8'h04, 32'h0000_0007);
      wr(fan_pkg::OFS_DOM_CFG, 32'h0064_0201);
      wr(fan_pkg::OFS_DOM_CFG + 8'h04, 32'h0064_0401);
      repeat (7 * PER) @(posedge CLK);
      rdchk("stat0", fan_pkg::OFS_DOM_STAT, 32'h0010_0202);
      rdchk("stat1", fan_pkg::OFS_DOM_STAT + 8'h04, 32'h0010_0404);
      chk("width0", 32'(mdl.hi_len[0]), 32'(2 * fan_pkg::PWM_PRE_CYCLES));
      chk("width1", 32'(mdl.hi_len[1]), 32'(4 * fan_pkg::PWM_PRE_CYCLES));
      chk("mcofs0", {24'h0, mdl.ofs[0]}, 32'h0000_0010);
      chk("mcofs1", {24'h0, mdl.ofs[1]}, 32'h0000_0007);
      rdchk("est0", fan_pkg::OFS_DIMM_EST, 32'h0000_1038);
      BOOST <= 2'b10;
      repeat (3) @(posedge CLK);
      rdchk("boost", fan_pkg::OFS_DOM_STAT + 8'h04, 32'h8240_0464);
      BOOST <= 2'b00;
      DIE_THERMAL_READING <= 8'h00;
      wr(fan_pkg::OFS_CTL_CFG, 32'h0000_0003);
      wr(fan_pkg::OFS_CTL_CFG + 8'h04, 32'h0001_0520);
      wr(fan_pkg::OFS_CTL_CFG + 8'h08, 32'h0000_0103);
      wr(fan_pkg::OFS_CTL_CFG + 8'h0C, 32'h0000_0310);
      wr(fan_pkg::OFS_CTL_CFG + 8'h10, 32'h0000_0201);
      wr(fan_pkg::OFS_CTL_CFG + 8'h14, 32'h0002_0430);
      wr(fan_pkg::OFS_DOM_CFG, 32'h0064_0200);
      tgt(8'h0C);
      wr(fan_pkg::OFS_CTL_CFG + 8'h10, 32'h0008_0201);
      BOARD_TEMP <= 16'h0036;
      tgt(8'h0C);
      BOARD_TEMP <= 16'h0040;
      tgt(8'h24);
      CPU_MARGIN <= 8'h00;
      tgt(8'h28);
      wr(fan_pkg::OFS_CTL_CFG + 8'h04, 32'h0004_0520);
      tgt(8'h64);
      wr(fan_pkg::OFS_CTL_CFG + 8'h18, 32'h0000_0205);
      wr(fan_pkg::OFS_CTL_CFG + 8'h1C, 32'h0000_09FF);
      tgt(8'h09);
      wr(fan_pkg::OFS_CTRL, 32'h0000_0001);
      tgt(8'h32);
      // Align to a tick first so the static pick meets exactly one averaging step
      do begin
         @(posedge CLK);
      end while (MC_OFS_WE[0] !== 1'b1);
      wr(fan_pkg::OFS_CTRL, 32'h0000_0003);
      do begin
         @(posedge CLK);
      end while (MC_OFS_WE[0] !== 1'b1);
      rdchk("est_static", fan_pkg::OFS_DIMM_EST, 32'h0000_0B33);
      chk("mcofs_static", {24'h0, mdl.ofs[0]}, 32'h0000_000B);
      AVS_BYTEENABLE <= 4'h2;
      wr(fan_pkg::OFS_RAMP, 32'hFFFF_0500);
      rdchk("ramp_be", fan_pkg::OFS_RAMP, 32'h0000_0501);
      summarize();
   end
endmodule
